// file: verilog/swl_map.vh
// constants for the serial wiper code loader
`ifndef SWL_MAP_VH
`define SWL_MAP_VH
`define SWL_WIDTH_256      8
`define SWL_WIDTH_33       6
`define SWL_TAPS_256       256
`define SWL_TAPS_33        33
`define SWL_TOP_CODE_256   8'hff
`define SWL_TOP_CODE_33    6'h20
`define SWL_MID_CODE_256   8'h80
`define SWL_MID_CODE_33    6'h10
`define SWL_PIN_IDLE       3'h7
`endif

// file: verilog/swl_tap_decoder.v
// wiper code to one-hot ladder tap decoder with saturation
`timescale 1ns/1ps
`include "swl_map.vh"
module swl_tap_decoder #(
	parameter WIDTH = 8,      // latch width
	parameter TAPS  = 256     // ladder tap count
) (
	input  wire [WIDTH-1:0] code,
	output reg  [TAPS-1:0]  tap_sel
);
	integer i;
	// one tap per code; codes past the last tap stay on the topmost tap
	always @* begin
		tap_sel = {TAPS{1'b0}};
		for (i = 0; i < TAPS; i = i + 1) begin
			if (code == i[WIDTH-1:0]) begin
				tap_sel[i] = 1'b1;
			end
		end
		if (code > TAPS - 1) begin
			tap_sel[TAPS-1] = 1'b1;
		end
	end
endmodule // swl_tap_decoder

// file: verilog/swl_wiper_loader.v
// serial wiper code loader: three-wire write-only input, latch and tap select
`timescale 1ns/1ps
`include "swl_map.vh"
module swl_wiper_loader #(
	parameter NARROW = 0    // 0: 256-tap variant, 1: 33-tap variant
) (
	input  wire         ref_clk,          // system clock
	input  wire         resetn,           // power-on reset, active low
	input  wire         serial_clk,       // host serial clock pin
	input  wire         chip_sel_n,       // host select pin, active low
	input  wire         serial_in,        // host serial data pin
	input  wire         power_down_n,     // shutdown pin, active low
	output reg  [7:0]   wiper_code_latch, // latched code, raw, low bits used
	output reg  [7:0]   wb_setting,       // wiper-to-B step count
	output reg  [7:0]   wa_setting,       // wiper-to-A step count
	output reg  [255:0] tap_sel,          // one-hot ladder tap, bit 0 at the B end
	output reg          a_switch_closed,  // high while the A terminal is connected
	output reg          wiper_short_b     // high while the wiper is shorted to B
);

	// variant geometry; every width below follows from the one NARROW switch
	localparam WIDTH = NARROW ? `SWL_WIDTH_33 : `SWL_WIDTH_256;
	localparam TAPS  = NARROW ? `SWL_TAPS_33 : `SWL_TAPS_256;
	localparam [7:0] MID  = NARROW ? {2'h0, `SWL_MID_CODE_33} : `SWL_MID_CODE_256;
	localparam [7:0] TOP  = NARROW ? {2'h0, `SWL_TOP_CODE_33} : `SWL_TOP_CODE_256;
	localparam [7:0] WA_RST = TOP - MID; // wiper-to-A count at the preset

	// two-stage synchronisers; stage one feeds only stage two
	reg [2:0]       sync_a;    // first stage: clk, cs_n, sdi
	reg [2:0]       sync_b;    // second stage
	reg             pdn_a;     // shutdown first stage
	reg             pdn_b;     // shutdown second stage

	// edge memories and the serial datapath
	reg             clk_prev;  // last synced serial clock
	reg             cs_prev;   // last synced select
	reg [WIDTH-1:0] shift_reg; // serial shift register
	reg [7:0]       code_q;    // latch held internally

	// combinational helpers
	wire [TAPS-1:0] dec_taps;  // decoder output
	wire [7:0]      clamped;   // code clipped to the top tap
	wire            clk_rise;  // synced serial clock went low to high
	wire            cs_rise;   // synced select went low to high
	wire            selected;  // synced select is low
	wire [7:0]      load_word; // shift register widened to the latch port
	wire [255:0]    tap_wide;  // decoder output widened to the tap port

	// rising edge between two successive samples of a re-timed pin
	function rising;
		input now;  // current sample
		input prev; // sample one clock earlier
		begin
			rising = now & ~prev;
		end
	endfunction

	// zero-extend a latch-width code to the eight-bit port;
	// a loop avoids a zero-width replication in the wide build
	function [7:0] widen_code;
		input [WIDTH-1:0] v; // code of latch width
		integer j;           // bit index
		begin
			widen_code = 8'h00;
			for (j = 0; j < WIDTH; j = j + 1) begin
				widen_code[j] = v[j];
			end
		end
	endfunction

	// zero-extend the decoder's taps to the full 256-bit port;
	// unused upper taps of the short ladder stay low
	function [255:0] widen_taps;
		input [TAPS-1:0] v; // one-hot taps of this variant
		integer j;          // tap index
		begin
			widen_taps = 256'h0;
			for (j = 0; j < TAPS; j = j + 1) begin
				widen_taps[j] = v[j];
			end
		end
	endfunction

	// all link pins are async to ref_clk, so they are re-timed first;
	// the idle value is high so that no false select edge follows reset
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync_a <= `SWL_PIN_IDLE;
			sync_b <= `SWL_PIN_IDLE;
			pdn_a  <= 1'b1; // not in shutdown while reset
			pdn_b  <= 1'b1;
		end else begin
			sync_a <= {serial_clk, chip_sel_n, serial_in};
			sync_b <= sync_a;
			pdn_a  <= power_down_n;
			pdn_b  <= pdn_a;
		end
	end

	// edge detection on the second stage only; the first stage may be metastable
	assign clk_rise = rising(sync_b[2], clk_prev);
	assign cs_rise  = rising(sync_b[1], cs_prev);
	assign selected = ~sync_b[1];

	// previous samples for the edge detectors
	// a reset value of one hides a clock that rests low from a false rise
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			clk_prev <= 1'b1;
			cs_prev  <= 1'b1;
		end else begin
			clk_prev <= sync_b[2];
			cs_prev  <= sync_b[1];
		end
	end

	// shift on a sampled clock rise while selected
	// limitation: each serial clock phase must last at least three ref_clk cycles
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			shift_reg <= {WIDTH{1'b0}};
		end else begin
			// interface stays live in shutdown so codes can change meanwhile
			if (selected && clk_rise) begin
				shift_reg <= {shift_reg[WIDTH-2:0], sync_b[0]};
			end
		end
	end

	// the whole word moves at once, so a partial word never reaches the ladder
	assign load_word = widen_code(shift_reg);

	// latch the word on a select rise; the clock level plays no part
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			code_q <= MID;
		end else begin
			if (cs_rise) begin
				code_q <= load_word;
			end
		end
	end

	// raw codes above full scale are kept in the latch; the settings and the tap saturate
	assign clamped = (code_q > TOP) ? TOP : code_q;

	// one-hot decode of the raw code; the decoder saturates on its own
	swl_tap_decoder #(
		.WIDTH (WIDTH),
		.TAPS  (TAPS)
	) u_dec (
		.code    (code_q[WIDTH-1:0]),
		.tap_sel (dec_taps)
	);

	assign tap_wide = widen_taps(dec_taps);

	// registered outputs; shutdown overrides the tap but never the latch
	// the settings keep tracking the latch in shutdown so the exit is seamless
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wiper_code_latch <= MID;    // preset shows before any transfer
			wb_setting       <= MID;
			wa_setting       <= WA_RST;
			tap_sel          <= 256'h0; // no tap until the first edge after release
			a_switch_closed  <= 1'b1;
			wiper_short_b    <= 1'b0;
		end else begin
			wiper_code_latch <= code_q;
			wb_setting       <= clamped;
			wa_setting       <= TOP - clamped;
			if (!pdn_b) begin
				// shutdown: wiper parked on the B-end tap, A side open
				tap_sel         <= 256'h1;
				a_switch_closed <= 1'b0;
				wiper_short_b   <= 1'b1;
			end else begin
				// normal: the stored code selects the tap again
				tap_sel         <= tap_wide;
				a_switch_closed <= 1'b1;
				wiper_short_b   <= 1'b0;
			end
		end
	end
endmodule // swl_wiper_loader

// file: tb/swl_loader_asserts.sv
// loader port checks for both ladder variants
`timescale 1ns/1ps
module swl_loader_asserts #(
	parameter NARROW = 0 // variant of the bound loader
) (
	input wire         ref_clk,
	input wire         resetn,
	input wire         chip_sel_n,
	input wire         power_down_n,
	input wire         a_switch_closed,
	input wire         wiper_short_b,
	input wire [7:0]   wiper_code_latch,
	input wire [7:0]   wb_setting,
	input wire [7:0]   wa_setting,
	input wire [255:0] tap_sel
);
	localparam [7:0] MID = NARROW ? 8'h10 : 8'h80; // midscale preset
	localparam [7:0] TOP = NARROW ? 8'h20 : 8'hff; // full-scale step
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_mid_rst: assert property ($rose(resetn) |-> wiper_code_latch == MID) else $error("mid");
	a_code_six: assert property (NARROW == 0 || wiper_code_latch[7:6] == 2'h0) else $error("msb");
	a_clamp_top: assert property ($stable(wiper_code_latch)[*3] |->
		wb_setting == (wiper_code_latch > TOP ? TOP : wiper_code_latch)) else $error("wb");
	a_wa_compl: assert property (wa_setting == TOP - wb_setting) else $error("wa");
	a_tap_step: assert property (($stable(wb_setting) && a_switch_closed)[*3] |->
		tap_sel == 256'h1 << wb_setting) else $error("tap");
	a_down_short: assert property ((!power_down_n)[*5] |-> wiper_short_b) else $error("off");
	a_pair_open: assert property (wiper_short_b == !a_switch_closed) else $error("ab");
	a_idle_hold: assert property ((!chip_sel_n)[*8] |-> $stable(wiper_code_latch)) else $error("cs");
	c_sat: cover property (wiper_code_latch > 8'h20);
	c_off: cover property (wiper_short_b);
	c_on: cover property ($rose(a_switch_closed));
endmodule // swl_loader_asserts
bind swl_wiper_loader swl_loader_asserts #(.NARROW(NARROW)) chk (
	.ref_clk          (ref_clk),
	.resetn           (resetn),
	.chip_sel_n       (chip_sel_n),
	.power_down_n     (power_down_n),
	.a_switch_closed  (a_switch_closed),
	.wiper_short_b    (wiper_short_b),
	.wiper_code_latch (wiper_code_latch),
	.wb_setting       (wb_setting),
	.wa_setting       (wa_setting),
	.tap_sel          (tap_sel)
);

// file: tb/swl_host.sv
// host model for the write link
`timescale 1ns/1ps
module swl_host #(
	parameter WIDTH = 6 // bits per word for the attached variant
) (
	output reg serial_clk = 1'b0, // rests low between words
	output reg chip_sel_n = 1'b1,
	output reg serial_in  = 1'b0
);
	// one full word, most significant bit first, 80 ns clock
	task send(input [7:0] w);
		integer i;
		#40 chip_sel_n = 0;
		for (i = WIDTH - 1; i >= 0; i = i - 1) begin
			serial_in = w[i];
			#40 serial_clk = 1;
			#40 serial_clk = 0;
		end
		#40 chip_sel_n = 1;
		serial_in = ~serial_in;
	endtask
	// clock pulses with select high; they must not reach the shift register
	task stray(input [7:0] w);
		integer i;
		for (i = WIDTH - 1; i >= 0; i = i - 1) begin
			#40 serial_in = w[i];
			#40 serial_clk = 1;
			#40 serial_clk = 0;
		end
	endtask
	// select pulse with the clock resting low: reloads the word unchanged
	task pulse_cs;
		#40 chip_sel_n = 0;
		#80 chip_sel_n = 1;
	endtask
endmodule // swl_host

// file: tb/serial_wiper_code_loader_tb.sv
// loader bench: both ladder variants side by side
`timescale 1ns/1ps
module serial_wiper_code_loader_tb;
	reg          ref_clk = 1'b0;
	reg          resetn = 1'b0;
	reg          power_down_n = 1'b1;
	wire         serial_clk, chip_sel_n, serial_in;       // 33-tap link
	wire         a_switch_closed, wiper_short_b;
	wire [7:0]   wiper_code_latch, wb_setting, wa_setting;
	wire [255:0] tap_sel;
	wire         w_clk, w_cs_n, w_sdi, w_a_closed, w_short_b; // 256-tap build
	wire [7:0]   w_latch, w_wb, w_wa;
	wire [255:0] w_tap;
	integer      err_total = 0;
	integer      checked = 0;
	integer      k;
	// wide code, narrow code, narrow step after clamping
	reg [23:0]   rows [0:4] = '{24'h000000, 24'h010101, 24'h802020, 24'hfe2120, 24'hff3f20};
	swl_wiper_loader #(.NARROW(1)) uut (
		.ref_clk (ref_clk), .resetn (resetn), .serial_clk (serial_clk), .chip_sel_n (chip_sel_n),
		.serial_in (serial_in), .power_down_n (power_down_n), .wiper_code_latch (wiper_code_latch),
		.wb_setting (wb_setting), .wa_setting (wa_setting), .tap_sel (tap_sel),
		.a_switch_closed (a_switch_closed), .wiper_short_b (wiper_short_b));
	swl_wiper_loader #(.NARROW(0)) uut_w (
		.ref_clk (ref_clk), .resetn (resetn), .serial_clk (w_clk), .chip_sel_n (w_cs_n),
		.serial_in (w_sdi), .power_down_n (power_down_n), .wiper_code_latch (w_latch),
		.wb_setting (w_wb), .wa_setting (w_wa), .tap_sel (w_tap),
		.a_switch_closed (w_a_closed), .wiper_short_b (w_short_b));
	swl_host #(.WIDTH(6)) hst (.serial_clk (serial_clk), .chip_sel_n (chip_sel_n), .serial_in (serial_in));
	swl_host #(.WIDTH(8)) hst_w (.serial_clk (w_clk), .chip_sel_n (w_cs_n), .serial_in (w_sdi));
	always #2 ref_clk = ~ref_clk;
	task cmp(input ok);
		checked = checked + 1;
		if (!ok) $display("wrong value at %0t: output", $time);
		err_total = err_total + !ok;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1;
		for (k = 0; k < 5; k = k + 1) begin
			fork
				hst.send(rows[k][15:8]);
				hst_w.send(rows[k][23:16]);
			join
			repeat (8) @(posedge ref_clk);
			#1 cmp(wiper_code_latch === rows[k][15:8] && wb_setting === rows[k][7:0]);
			cmp(wa_setting === 8'h20 - rows[k][7:0]);
			cmp(tap_sel === 256'h1 << rows[k][7:0]);
			cmp(w_latch === rows[k][23:16] && w_wb === rows[k][23:16]);
			cmp(w_wa === 8'hff - rows[k][23:16]);
			cmp(w_tap === 256'h1 << rows[k][23:16]);
		end
		// clocks with select high are ignored; a bare select pulse reloads the word
		hst.send(8'h05);
		hst.stray(8'h3f);
		hst.pulse_cs;
		repeat (8) @(posedge ref_clk);
		#1 cmp(wiper_code_latch === 8'h05);
		@(posedge ref_clk) power_down_n <= 0;
		hst.send(8'h03);
		repeat (8) @(posedge ref_clk);
		#1 cmp(tap_sel === 256'h1 && wiper_short_b === 1'b1 && a_switch_closed === 1'b0);
		cmp(w_tap === 256'h1 && w_short_b === 1'b1 && w_a_closed === 1'b0);
		cmp(wiper_code_latch === 8'h03);
		@(posedge ref_clk) power_down_n <= 1;
		repeat (8) @(posedge ref_clk);
		#1 cmp(tap_sel === 256'h8 && a_switch_closed === 1'b1 && wiper_short_b === 1'b0);
		cmp(w_tap === 256'h1 << 8'hff && w_a_closed === 1'b1);
		// second reset in mid-run brings both variants back to midscale
		@(posedge ref_clk) resetn <= 0;
		@(posedge ref_clk);
		#1 cmp(wiper_code_latch === 8'h10 && tap_sel === 256'h0 && w_latch === 8'h80);
		repeat (5) @(posedge ref_clk);
		resetn <= 1;
		repeat (2) @(posedge ref_clk);
		#1 cmp(tap_sel === 256'h1 << 8'h10 && w_tap === 256'h1 << 8'h80);
		summarize;
	end
	// the tests take about 6000 ns; five times that is a hang
	initial begin
		#30000 err_total = err_total + 1;
		summarize;
	end
	task summarize;
		if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
endmodule // serial_wiper_code_loader_tb
